//--- inc/irq_arb_map.vh
// Constants for the four-level interrupt arbiter
`ifndef IRQ_ARB_MAP_VH
`define IRQ_ARB_MAP_VH

// ==========================================================
// Source indices, natural order (index 0 ranks best)
`define SRC_PIN0        3'h0
`define SRC_TMR0        3'h1
`define SRC_PIN1        3'h2
`define SRC_TMR1        3'h3
`define SRC_SERIAL      3'h4
`define SRC_TMR2        3'h5
`define SRC_PIN2        3'h6
`define SRC_PIN3        3'h7
`define NUM_SRC         8

// ==========================================================
// Vector table
`define VEC_BASE        16'h0003
`define VEC_STEP_SHIFT  3

// ==========================================================
// Priority levels
`define LVL_0           2'h0
`define LVL_1           2'h1
`define LVL_2           2'h2
`define LVL_3           2'h3

// ==========================================================
// Reset values
`define RST_SRC_MASK    8'h00
`define RST_PIN_FLAGS   4'h0
`define RST_IN_SVC      4'h0

// ==========================================================
// Pin type select encoding
`define PIN_TYPE_LEVEL  1'b0
`define PIN_TYPE_EDGE   1'b1

`endif

//--- logic/four_level_interrupt_arbiter.v
// Four-level vectored interrupt arbiter for eight sources
// Notes on behaviour
// RL1: Software clears most request flags; an uncleared flag re-enters its handler endlessly.
// RL2: Priority level per source is {high bit, low bit}, 00 lowest, 11 highest.
// RL3: Running handler is preempted only by a strictly higher level request.
// RL4: A level three handler is never preempted.
// RL5: Equal-level ties go to best natural rank: ext0,tmr0,ext1,tmr1,serial,tmr2,ext2,ext3.
// RL6: Vector is 0003H plus eight times natural index, up to 003BH.
// RL7: Serial request is rx OR tx done; timer 2 is overflow OR capture/reload.
// RL8: Only external pins 0 to 3 may wake the core from power-down.
// RL9: A source with its enable clear never raises a request.
// RL10: Edge mode samples each pin per machine cycle; high then low sets flag.
// RL11: Edge flags of pins 0 and 1 clear when the core enters their handler; the code clears the edge flags of pins 2 and 3 on entry as well.
// RL12: Pin 2 in level mode: flag follows the inverted pin level.
// RL13: A request that cannot preempt stays pending and is granted after return.
`timescale 1ns/10ps
`default_nettype none
`include "irq_arb_map.vh"

module four_level_interrupt_arbiter
#(
   parameter NSRC = `NUM_SRC
)
(
   // Clock, reset, enable
   input  wire        mclk,
   input  wire        srst,
   input  wire        ce,
   // Machine cycle strobe from core timing
   input  wire        mcyc_tick,
   // External interrupt pins, active low
   input  wire [3:0]  ext_irq_pin_n,
   // Pin mode and software flag clears
   input  wire [3:0]  pin_type_sel,
   input  wire [3:0]  pin_flag_clr,
   // Peripheral request flags
   input  wire        tmr0_ovf_flag,
   input  wire        tmr1_ovf_flag,
   input  wire        tmr2_ovf_flag,
   input  wire        tmr2_capreload_flag,
   input  wire        serial_rx_done,
   input  wire        serial_tx_done,
   // Enables and priorities, natural index order
   input  wire [7:0]  src_irq_en,
   input  wire [7:0]  prio_high_reg,
   input  wire [7:0]  prio_low_reg,
   // Core handshake
   input  wire        core_ack,
   input  wire        core_reti,
   output wire        irq_req,
   output wire [15:0] irq_vector,
   output wire [2:0]  irq_src,
   output wire [1:0]  irq_level,
   // Status
   output wire [3:0]  pin_req_flags,
   output wire [3:0]  in_service,
   output wire        wake_req
);

   // ==========================================================
   // Helper functions
   function [1:0] src_level;
      input [7:0] hi;
      input [7:0] lo;
      input [2:0] idx;
      begin
         src_level = {hi[idx], lo[idx]};  // [RL2]
      end
   endfunction

   function [15:0] vec_of;
      input [2:0] idx;
      begin
         vec_of = `VEC_BASE + ({13'h0000, idx} << `VEC_STEP_SHIFT);  // [RL6]
      end
   endfunction

   function [1:0] top_level;
      input [3:0] svc;
      begin
         if (svc[3])
            top_level = `LVL_3;
         else if (svc[2])
            top_level = `LVL_2;
         else if (svc[1])
            top_level = `LVL_1;
         else
            top_level = `LVL_0;
      end
   endfunction

   // ==========================================================
   // External pin sampling
   wire [3:0] pin_level;
   wire [3:0] pin_fall;

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1)
      begin : g_pin
         pin_sampler u_samp
         (
            .mclk      (mclk),
            .srst      (srst),
            .ce        (ce),
            .mcyc_tick (mcyc_tick),
            .pin_async (ext_irq_pin_n[g]),
            .pin_level (pin_level[g]),
            .pin_fall  (pin_fall[g])
         );
      end
   endgenerate

   // ==========================================================
   // State
   reg [3:0]  pin_edge_r;
   reg [3:0]  pin_edge_nxt;
   reg [3:0]  in_svc_r;
   reg [3:0]  in_svc_nxt;
   reg        req_r;
   reg        req_nxt;
   reg [2:0]  src_r;
   reg [1:0]  lvl_r;
   reg [15:0] vec_r;
   reg        wake_r;

   // ==========================================================
   // Request vector
   wire [3:0] pin_flag;
   wire [7:0] raw_req;
   wire [7:0] live_req;

   // Level mode follows the inverted pin; edge mode latches
   assign pin_flag[0] = pin_type_sel[0] ? pin_edge_r[0] : ~pin_level[0];
   assign pin_flag[1] = pin_type_sel[1] ? pin_edge_r[1] : ~pin_level[1];
   assign pin_flag[2] = pin_type_sel[2] ? pin_edge_r[2] : ~pin_level[2];  // [RL12]
   assign pin_flag[3] = pin_type_sel[3] ? pin_edge_r[3] : ~pin_level[3];

   assign raw_req[`SRC_PIN0]   = pin_flag[0];
   assign raw_req[`SRC_TMR0]   = tmr0_ovf_flag;
   assign raw_req[`SRC_PIN1]   = pin_flag[1];
   assign raw_req[`SRC_TMR1]   = tmr1_ovf_flag;
   assign raw_req[`SRC_SERIAL] = serial_rx_done | serial_tx_done;       // [RL7]
   assign raw_req[`SRC_TMR2]   = tmr2_ovf_flag | tmr2_capreload_flag;  // [RL7]
   assign raw_req[`SRC_PIN2]   = pin_flag[2];
   assign raw_req[`SRC_PIN3]   = pin_flag[3];

   assign live_req = raw_req & src_irq_en;  // [RL9]

   // ==========================================================
   // Arbitration: highest level, then best natural rank
   reg [2:0] win_idx;
   reg [1:0] win_lvl;
   reg       win_any;
   reg [1:0] cur_lvl;
   reg       can_preempt;
   integer   i;

   always @*
   begin
      win_idx = 3'h0;
      win_lvl = `LVL_0;
      win_any = 1'b0;
      // Descending scan so the lower index wins a tie
      for (i = NSRC - 1; i >= 0; i = i - 1)
      begin
         if (live_req[i] &&
             (!win_any || src_level(prio_high_reg, prio_low_reg, i[2:0]) >= win_lvl))
         begin
            win_any = 1'b1;
            win_idx = i[2:0];  // [RL5]
            win_lvl = src_level(prio_high_reg, prio_low_reg, i[2:0]);
         end
      end
      cur_lvl = top_level(in_svc_r);
      // Idle core takes any request; otherwise strictly higher only
      if (in_svc_r == `RST_IN_SVC)
         can_preempt = win_any;
      else if (in_svc_r[3])
         can_preempt = 1'b0;  // [RL4]
      else
         can_preempt = win_any && (win_lvl > cur_lvl);  // [RL3]
   end

   // ==========================================================
   // Next-state logic
   reg       ack_ok;
   reg [3:0] ack_clr;
   reg [1:0] reti_lvl;
   reg [3:0] svc_clr;

   always @*
   begin
      ack_ok   = core_ack & req_r;
      ack_clr  = 4'h0;
      reti_lvl = top_level(in_svc_r);
      svc_clr  = 4'h0;
      if (ack_ok && pin_type_sel[0] && src_r == `SRC_PIN0)
         ack_clr[0] = 1'b1;  // [RL11]
      if (ack_ok && pin_type_sel[1] && src_r == `SRC_PIN1)
         ack_clr[1] = 1'b1;  // [RL11]
      if (ack_ok && pin_type_sel[2] && src_r == `SRC_PIN2)
         ack_clr[2] = 1'b1;
      if (ack_ok && pin_type_sel[3] && src_r == `SRC_PIN3)
         ack_clr[3] = 1'b1;
      // New edges win over software or entry clears
      pin_edge_nxt = (pin_edge_r & ~(pin_flag_clr | ack_clr)) | (pin_fall & pin_type_sel);
      // A return retires only the innermost level
      if (core_reti && in_svc_r != `RST_IN_SVC)
         svc_clr[reti_lvl] = 1'b1;
      in_svc_nxt = in_svc_r & ~svc_clr;
      if (ack_ok)
         in_svc_nxt[lvl_r] = 1'b1;
      // Held one cycle low after an ack so the old grant is not repeated
      // Frozen offer drops once its own source is cleared or disabled
      req_nxt = can_preempt & ~core_ack & ~core_reti &
                (~req_r | live_req[src_r]);  // [RL9] [RL13]
   end

   // ==========================================================
   // Registers
   always @(posedge mclk)
   begin
      if (srst)
      begin
         pin_edge_r <= `RST_PIN_FLAGS;
         in_svc_r   <= `RST_IN_SVC;
         req_r      <= 1'b0;
         src_r      <= 3'h0;
         lvl_r      <= `LVL_0;
         vec_r      <= `VEC_BASE;
         wake_r     <= 1'b0;
      end
      else if (ce)
      begin
         pin_edge_r <= pin_edge_nxt;
         in_svc_r   <= in_svc_nxt;
         req_r      <= req_nxt;
         // Grant fields frozen while a request is offered
         if (!req_r || !req_nxt)
         begin
            src_r <= win_idx;
            lvl_r <= win_lvl;
            vec_r <= vec_of(win_idx);  // [RL6]
         end
         // Timer and serial requests are kept out of wake-up
         wake_r <= live_req[`SRC_PIN0] | live_req[`SRC_PIN1] |
                   live_req[`SRC_PIN2] | live_req[`SRC_PIN3];  // [RL8]
      end
   end

   // ==========================================================
   // Outputs
   assign irq_req       = req_r;
   assign irq_vector    = vec_r;
   assign irq_src       = src_r;
   assign irq_level     = lvl_r;
   assign pin_req_flags = pin_flag;
   assign in_service    = in_svc_r;
   assign wake_req      = wake_r;

endmodule // four_level_interrupt_arbiter

`default_nettype wire

//--- logic/pin_sampler.v
// Pin synchroniser and per-machine-cycle falling-edge sampler
`timescale 1ns/10ps
`default_nettype none

module pin_sampler
(
   // Clock and reset
   input  wire mclk,
   input  wire srst,
   input  wire ce,
   // Machine cycle strobe
   input  wire mcyc_tick,
   // Asynchronous pin
   input  wire pin_async,
   // Results
   output wire pin_level,
   output wire pin_fall
);

   // ==========================================================
   // Two-stage synchroniser
   reg sync1_r;
   reg sync2_r;
   reg samp_cur_r;
   reg fall_r;

   always @(posedge mclk)
   begin
      if (srst)
      begin
         sync1_r     <= 1'b1;
         sync2_r     <= 1'b1;
         samp_cur_r  <= 1'b1;
         fall_r      <= 1'b0;
      end
      else if (ce)
      begin
         sync1_r <= pin_async;
         sync2_r <= sync1_r;
         fall_r  <= 1'b0;
         // One sample per machine cycle; high then low is an edge
         if (mcyc_tick)
         begin
            samp_cur_r  <= sync2_r;
            fall_r      <= samp_cur_r & ~sync2_r;  // [RL10]
         end
      end
   end

   assign pin_level = sync2_r;
   assign pin_fall  = fall_r;

endmodule // pin_sampler

`default_nettype wire

//--- testbench/core_model.sv
// Behavioural core that enters and leaves interrupt handlers
`timescale 1ns/10ps
`default_nettype none
module core_model
(
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       srst,
   // Arbiter side
   input  wire logic       irq_req,
   output var  logic       core_ack,
   output var  logic       core_reti,
   // Bench control
   input  wire logic       ack_on,
   input  wire logic [3:0] ack_wait,
   input  wire logic       reti_cmd
);
   logic [3:0] wait_r;
   // ====================
   // Entry and return
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         wait_r    <= 4'h0;
         core_ack  <= 1'b0;
         core_reti <= 1'b0;
      end
      else
      begin
         // Guard stops a second entry while the offer is still dropping
         core_ack  <= irq_req && ack_on && !core_ack && wait_r == ack_wait;
         // Counts only while entry is allowed, so a long offer cannot wrap it
         wait_r    <= (irq_req && ack_on && !core_ack) ? wait_r + 4'h1 : 4'h0;
         core_reti <= reti_cmd;
      end
   end
endmodule // core_model
`default_nettype wire

//--- testbench/four_level_interrupt_arbiter_monitor.sv
// Assertion checker for the four-level interrupt arbiter
`timescale 1ns/10ps
`default_nettype none
module four_level_interrupt_arbiter_monitor
(
   // Clock and reset
   input wire logic        mclk,
   input wire logic        srst,
   input wire logic        ce,
   // Configuration
   input wire logic [7:0]  src_irq_en,
   input wire logic [7:0]  prio_high_reg,
   input wire logic [7:0]  prio_low_reg,
   input wire logic [3:0]  pin_req_flags,
   // Core handshake
   input wire logic        core_ack,
   input wire logic        irq_req,
   input wire logic [15:0] irq_vector,
   input wire logic [2:0]  irq_src,
   input wire logic [1:0]  irq_level,
   input wire logic [3:0]  in_service,
   input wire logic        wake_req
);
   logic [7:0] en_r;
   logic [7:0] hi_r;
   logic [7:0] lo_r;
   logic       wake_r;
   // ====================
   // Inputs as the arbiter saw them one edge back
   always_ff @(posedge mclk)
   begin
      en_r   <= src_irq_en;
      hi_r   <= prio_high_reg;
      lo_r   <= prio_low_reg;
      wake_r <= |(pin_req_flags & {src_irq_en[7:6], src_irq_en[2], src_irq_en[0]});
   end
   // ====================
   // Properties
   default clocking dc @(posedge mclk); endclocking
   default disable iff (srst);
   sequence entry_s;
      ce && core_ack && irq_req;
   endsequence
   vec_map_a: assert property (irq_req |-> irq_vector == 16'h0003 + {10'h000, irq_src, 3'h0})
      else $error("vector does not match source");
   svc_set_a: assert property (entry_s |=> in_service[$past(irq_level)])
      else $error("entry did not mark level in service");
   entry_drop_a: assert property (entry_s |=> !irq_req)
      else $error("offer stood after entry");
   top_block_a: assert property (in_service[3] |-> !irq_req)
      else $error("offer made over top level handler");
   preempt_level_a: assert property (irq_req |-> (in_service >> irq_level) == 4'h0)
      else $error("offer not above running level");
   enable_gate_a: assert property ($rose(irq_req) |-> en_r[irq_src])
      else $error("offer from disabled source");
   level_map_a: assert property ($rose(irq_req) |-> irq_level == {hi_r[irq_src], lo_r[irq_src]})
      else $error("offered level differs from priority bits");
   wake_pin_a: assert property (!$past(srst) && $past(ce) |-> wake_req == wake_r)
      else $error("wake differs from enabled pin requests");
endmodule // four_level_interrupt_arbiter_monitor
bind four_level_interrupt_arbiter four_level_interrupt_arbiter_monitor u_mon
   (.mclk(mclk), .srst(srst), .ce(ce), .src_irq_en(src_irq_en),
    .prio_high_reg(prio_high_reg), .prio_low_reg(prio_low_reg),
    .pin_req_flags(pin_req_flags), .core_ack(core_ack), .irq_req(irq_req),
    .irq_vector(irq_vector), .irq_src(irq_src), .irq_level(irq_level),
    .in_service(in_service), .wake_req(wake_req));
`default_nettype wire

//--- testbench/four_level_interrupt_arbiter_tb.sv
// Self-checking bench for the four-level interrupt arbiter
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin miscompares++; \
   $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module four_level_interrupt_arbiter_tb;
   logic mclk = 0, srst = 1, mcyc_tick = 0, ack_on = 0, reti_cmd = 0;
   logic [1:0] tc = 2'h0;
   logic [3:0] pin_n = 4'hF, type_sel = 4'h0, ack_wait = 4'h0, clr = 4'h0;
   logic [5:0] fl = 6'h00;
   logic [7:0] en = 8'h00, ph = 8'h00, pl = 8'h00;
   wire core_ack, core_reti, irq_req, wake_req;
   wire [15:0] vec;
   wire [2:0] src;
   wire [1:0] lvl;
   wire [3:0] pflags, svc;
   int miscompares = 0, n_compared = 0;
   initial forever #12.5 mclk = ~mclk;
   always @(posedge mclk)
   begin
      tc <= tc + 2'h1;
      mcyc_tick <= (tc == 2'h3);
   end
   four_level_interrupt_arbiter u_four_level_interrupt_arbiter
      (.mclk(mclk), .srst(srst), .ce(1'b1), .mcyc_tick(mcyc_tick), .ext_irq_pin_n(pin_n),
       .pin_type_sel(type_sel), .pin_flag_clr(clr), .tmr0_ovf_flag(fl[0]),
       .tmr1_ovf_flag(fl[1]), .tmr2_ovf_flag(fl[2]), .tmr2_capreload_flag(fl[3]),
       .serial_rx_done(fl[4]), .serial_tx_done(fl[5]), .src_irq_en(en),
       .prio_high_reg(ph), .prio_low_reg(pl), .core_ack(core_ack), .core_reti(core_reti),
       .irq_req(irq_req), .irq_vector(vec), .irq_src(src), .irq_level(lvl),
       .pin_req_flags(pflags), .in_service(svc), .wake_req(wake_req));
   core_model u_core_model
      (.mclk(mclk), .srst(srst), .irq_req(irq_req), .core_ack(core_ack),
       .core_reti(core_reti), .ack_on(ack_on), .ack_wait(ack_wait), .reti_cmd(reti_cmd));
   // ====================
   // Shared steps
   task w(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task take;
      int k;
      begin
         @(posedge mclk) ack_on <= 1'b1;
         for (k = 0; k < 20 && core_ack !== 1'b1; k++) w(1);
         @(posedge mclk) ack_on <= 1'b0;
         #1;
      end
   endtask
   task ret;
      @(posedge mclk) reti_cmd <= 1'b1;
      @(posedge mclk) reti_cmd <= 1'b0;
      w(5);
   endtask
   // ====================
   // Scenarios
   task t_walk;
      @(posedge mclk) begin fl <= 6'h01; en <= 8'h02; end
      w(3);
      `CHK(vec, 16'h000B)
      `CHK(wake_req, 1'b0)
      take;
      `CHK(svc, 4'h1)
      w(3);
      `CHK(irq_req, 1'b0)
      @(posedge mclk) fl <= 6'h00;
      ret;
      `CHK(svc, 4'h0)
      $display("walk done");
   endtask
   task t_tie;
      @(posedge mclk) begin fl <= 6'h3A; en <= 8'h38; ack_wait <= 4'h3; end
      w(3);
      `CHK(vec, 16'h001B)
      @(posedge mclk) en <= 8'h30;
      w(4);
      `CHK(vec, 16'h0023)
      @(posedge mclk) begin fl <= 6'h28; en <= 8'h20; end
      w(4);
      `CHK(vec, 16'h002B)
      take;
      @(posedge mclk) fl <= 6'h00;
      ret;
      `CHK(svc, 4'h0)
      $display("tie done");
   endtask
   task t_preempt;
      @(posedge mclk) begin ph <= 8'h22; pl <= 8'h3A; en <= 8'h08; fl <= 6'h02; end
      w(3);
      `CHK(lvl, 2'h1)
      take;
      @(posedge mclk) begin en <= 8'h38; fl <= 6'h16; end
      w(3);
      `CHK(vec, 16'h002B)
      `CHK(lvl, 2'h3)
      take;
      `CHK(svc, 4'hA)
      @(posedge mclk) begin en <= 8'h3A; fl <= 6'h17; end
      w(4);
      `CHK(irq_req, 1'b0)
      @(posedge mclk) fl <= 6'h13;
      ret;
      `CHK(vec, 16'h000B)
      @(posedge mclk) begin fl <= 6'h00; en <= 8'h00; end
      ret;
      `CHK(svc, 4'h0)
      $display("preempt done");
   endtask
   task t_pin;
      @(posedge mclk) begin type_sel <= 4'h1; en <= 8'h01; end
      w(12);
      @(posedge mclk) pin_n <= 4'hE;
      w(16);
      `CHK(pflags[0], 1'b1)
      `CHK(wake_req, 1'b1)
      `CHK(vec, 16'h0003)
      @(posedge mclk) pin_n <= 4'hF;
      take;
      w(1);
      `CHK(pflags[0], 1'b0)
      ret;
      @(posedge mclk) pin_n <= 4'hE;
      w(16);
      `CHK(pflags[0], 1'b1)
      @(posedge mclk) clr <= 4'h1;
      @(posedge mclk) clr <= 4'h0;
      w(1);
      `CHK(pflags[0], 1'b0)
      @(posedge mclk) pin_n <= 4'hB;
      w(5);
      `CHK(pflags[2], 1'b1)
      `CHK(irq_req, 1'b0)
      `CHK(wake_req, 1'b0)
      @(posedge mclk) pin_n <= 4'hF;
      w(5);
      `CHK(pflags[2], 1'b0)
      $display("pin done");
   endtask
   task end_of_test;
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Whole run is under two hundred cycles; this is far beyond it
   initial
   begin
      #50000;
      miscompares++;
      end_of_test;
   end
   initial
   begin
      w(7);
      @(posedge mclk) srst <= 1'b0;
      t_walk;
      t_tie;
      t_preempt;
      t_pin;
      end_of_test;
   end
endmodule // four_level_interrupt_arbiter_tb
`default_nettype wire
